// >>> hdl/lsc_pkg.sv
// constants, states and carriers of the light sensor control block
package lsc_pkg;

  // register offsets
  localparam logic [6:0] REG_CTL = 7'h00;
  localparam logic [6:0] REG_LO  = 7'h01;
  localparam logic [6:0] REG_HI  = 7'h02;
  // pointer-byte bit that restarts integration
  localparam int         PTR_SYNC_BIT = 7;

  // reset values
  localparam logic [7:0]  CTL_RST = 8'h00;
  localparam logic [15:0] RES_RST = 16'h0000;

  // control byte fields
  localparam int CTL_EN   = 7;
  localparam int CTL_CONT = 6;
  localparam int CTL_IR   = 5;
  localparam int CTL_EXT  = 4;   // ext_timing_sel
  localparam int CTL_WHI  = 3;   // conv_width_hi
  localparam int CTL_WLO  = 2;   // conv_width_lo
  localparam int CTL_SHI  = 1;   // scale_sel_hi
  localparam int CTL_SLO  = 0;   // scale_sel_lo

  // upper six bits of the 7-bit bus address
  localparam logic [5:0] DEV_ADDR_HI = 6'h22;

  // integration lengths in oscillator cycles
  localparam int unsigned CYC_W16 = 65536;
  localparam int unsigned CYC_W12 = 4096;
  localparam int unsigned CYC_W8  = 256;
  localparam int unsigned CYC_W4  = 16;
  localparam logic [15:0] CNT_MAX = 16'hFFFF;

  typedef enum logic [1:0] {
    L_IDLE  = 2'b00,
    L_ADDR  = 2'b01,
    L_WRITE = 2'b10,
    L_READ  = 2'b11
  } lsc_lst_t;

  typedef enum logic [1:0] {
    M_OFF  = 2'b00,
    M_WAIT = 2'b01,
    M_RUN  = 2'b10
  } lsc_mst_t;

  // drive to the analog front end
  typedef struct packed {
    logic       fe_on;
    logic       ir_sel;
    logic [1:0] full_scale_span;
  } lsc_fe_t;

  // state on the bus clock
  typedef struct packed {
    logic       rst_s1;
    logic       rst_s2;
    logic       asel_s1;
    logic       asel_s2;
    logic       res_s1;
    logic       res_s2;
    logic       res_seen;
    logic [15:0] res_copy;
    lsc_lst_t   st;
    logic [3:0] cnt;
    logic [7:0] sh;
    logic       rd;
    logic       ptr_phase;
    logic [6:0] ptr;
    logic [7:0] ctl_shadow;
    logic       ctl_tog;
    logic       sync_tog;
    logic       sda_oe;
  } lsc_link_t;

  // state on the oscillator clock
  typedef struct packed {
    logic        ctl_s1;
    logic        ctl_s2;
    logic        ctl_seen;
    logic        syn_s1;
    logic        syn_s2;
    logic        syn_seen;
    logic        pls_s1;
    logic        pls_s2;
    logic        pls_last;
    logic [7:0]  ctl;
    lsc_mst_t    st;
    logic [15:0] cyc;
    logic [15:0] acc;
    logic [15:0] res;
    logic        res_tog;
  } lsc_meas_t;

endpackage

// >>> hdl/lsc_top.sv
// bus slave, control register and conversion sequencer of the light sensor
`timescale 1ns/1ps
module lsc_top #(
  parameter int unsigned INT_CYC_16 = lsc_pkg::CYC_W16
) (
  input  wire logic           mclk,
  input  wire logic           rst_n,
  input  wire logic           scl,
  input  wire logic           sda_in,
  output logic                sda_out,
  output logic                sda_oe,
  input  wire logic           addr_select_pin,
  input  wire logic           light_pulse,
  output lsc_pkg::lsc_fe_t    fe
);

  localparam lsc_pkg::lsc_link_t L_RST = '{
    rst_s1: 1'b0, rst_s2: 1'b0, asel_s1: 1'b0, asel_s2: 1'b0,
    res_s1: 1'b0, res_s2: 1'b0, res_seen: 1'b0,
    res_copy: lsc_pkg::RES_RST, st: lsc_pkg::L_IDLE, cnt: 4'h0,
    sh: 8'h00, rd: 1'b0, ptr_phase: 1'b0, ptr: lsc_pkg::REG_CTL,
    ctl_shadow: lsc_pkg::CTL_RST, ctl_tog: 1'b0, sync_tog: 1'b0,
    sda_oe: 1'b0};

  localparam lsc_pkg::lsc_meas_t M_RST = '{
    ctl_s1: 1'b0, ctl_s2: 1'b0, ctl_seen: 1'b0,
    syn_s1: 1'b0, syn_s2: 1'b0, syn_seen: 1'b0,
    pls_s1: 1'b0, pls_s2: 1'b0, pls_last: 1'b0,
    ctl: lsc_pkg::CTL_RST, st: lsc_pkg::M_OFF, cyc: 16'h0000,
    acc: 16'h0000, res: lsc_pkg::RES_RST, res_tog: 1'b0};

  lsc_pkg::lsc_link_t l_q;
  lsc_pkg::lsc_link_t l_d;
  lsc_pkg::lsc_meas_t m_q;
  lsc_pkg::lsc_meas_t m_d;
  logic               sda_pos_q;
  logic               start;
  logic               addr_hit;
  logic [7:0]         sh_nx;
  logic [7:0]         rd_byte;
  logic               ctl_new;
  logic               sync_new;
  logic               pulse;
  logic               ext;
  logic               tmr;
  logic               cont;
  logic               done;
  logic               shadow_bad;
  logic [15:0]        lim_m1;
  logic [15:0]        acc_max;
  logic [15:0]        acc_nx;

  function automatic logic [16:0] int_cycles(input logic [1:0] w);
    unique case (w)
      2'h0: int_cycles = 17'(INT_CYC_16);
      2'h1: int_cycles = 17'(lsc_pkg::CYC_W12);
      2'h2: int_cycles = 17'(lsc_pkg::CYC_W8);
      2'h3: int_cycles = 17'(lsc_pkg::CYC_W4);
    endcase
  endfunction

  // ---- bus side, clocked by the master's scl ----
  // sda sampled while scl is high; a fall seen at the next scl fall is a start
  always_ff @(posedge scl) begin
    sda_pos_q <= sda_in;
  end

  assign start    = sda_pos_q & ~sda_in;
  assign sh_nx    = {l_q.sh[6:0], sda_in};
  assign addr_hit = l_q.sh[6:0] == {lsc_pkg::DEV_ADDR_HI, l_q.asel_s2};

  always_comb begin
    unique case (l_q.ptr)
      lsc_pkg::REG_CTL: rd_byte = l_q.ctl_shadow;
      lsc_pkg::REG_LO:  rd_byte = l_q.res_copy[7:0];
      lsc_pkg::REG_HI:  rd_byte = l_q.res_copy[15:8];
      default:          rd_byte = 8'h00;
    endcase
  end

  always_comb begin
    l_d = l_q;
    l_d.rst_s1 = rst_n;
    l_d.rst_s2 = l_q.rst_s1;
    l_d.asel_s1 = addr_select_pin;
    l_d.asel_s2 = l_q.asel_s1;
    l_d.res_s1 = m_q.res_tog;
    l_d.res_s2 = l_q.res_s1;
    l_d.res_seen = l_q.res_s2;
    // result word is stable for many cycles after its toggle
    if (l_q.res_s2 != l_q.res_seen) begin
      l_d.res_copy = m_q.res;
    end
    if (start) begin
      l_d.st = lsc_pkg::L_ADDR;
      l_d.cnt = 4'h0;
      l_d.sda_oe = 1'b0;
    end else begin
      unique case (l_q.st)
        lsc_pkg::L_IDLE: begin
          l_d.sda_oe = 1'b0;
        end
        lsc_pkg::L_ADDR, lsc_pkg::L_WRITE: begin
          if (l_q.cnt != 4'h8) begin
            l_d.sh  = sh_nx;
            l_d.cnt = 4'(l_q.cnt + 4'h1);
            if (l_q.cnt == 4'h7) begin
              if (l_q.st == lsc_pkg::L_ADDR) begin
                if (addr_hit) begin
                  l_d.sda_oe = 1'b1;
                  l_d.rd = sda_in;
                end else begin
                  l_d.st = lsc_pkg::L_IDLE;
                end
              end else begin
                l_d.sda_oe = 1'b1;
                if (l_q.ptr_phase) begin
                  l_d.ptr = sh_nx[6:0];
                  l_d.ptr_phase = 1'b0;
                  if (sh_nx[lsc_pkg::PTR_SYNC_BIT]) begin
                    l_d.sync_tog = ~l_q.sync_tog;
                  end
                end else if (l_q.ptr == lsc_pkg::REG_CTL) begin
                  l_d.ctl_shadow = sh_nx;
                  l_d.ctl_tog = ~l_q.ctl_tog;
                end
                // result bytes are read-only: data acked, dropped
              end
            end
          end else begin
            l_d.cnt = 4'h0;
            l_d.sda_oe = 1'b0;
            if (l_q.st == lsc_pkg::L_ADDR) begin
              if (l_q.rd) begin
                l_d.st = lsc_pkg::L_READ;
                l_d.sh = rd_byte;
                l_d.sda_oe = ~rd_byte[7];
              end else begin
                l_d.st = lsc_pkg::L_WRITE;
                l_d.ptr_phase = 1'b1;
              end
            end
          end
        end
        lsc_pkg::L_READ: begin
          if (l_q.cnt != 4'h8) begin
            l_d.cnt = 4'(l_q.cnt + 4'h1);
            l_d.sh  = {l_q.sh[6:0], 1'b0};
            // bit 0 done: let go so the master can acknowledge
            l_d.sda_oe = (l_q.cnt == 4'h7) ? 1'b0 : ~l_q.sh[6];
          end else if (!sda_in) begin
            l_d.cnt = 4'h0;
            l_d.sh  = rd_byte;
            l_d.sda_oe = ~rd_byte[7];
          end else begin
            l_d.st = lsc_pkg::L_IDLE;
            l_d.cnt = 4'h0;
            l_d.sda_oe = 1'b0;
          end
        end
      endcase
    end
  end

  // driven bits change only while scl is low
  always_ff @(negedge scl) begin
    if (!l_q.rst_s2) begin
      l_q <= L_RST;
      l_q.rst_s1 <= l_d.rst_s1;
      l_q.rst_s2 <= l_d.rst_s2;
    end else begin
      l_q <= l_d;
    end
  end

  assign sda_out = 1'b0;
  assign sda_oe  = l_q.sda_oe;

  // ---- conversion side, clocked by the oscillator ----
  assign ctl_new  = m_q.ctl_s2 != m_q.ctl_seen;
  assign sync_new = m_q.syn_s2 != m_q.syn_seen;
  assign pulse    = m_q.pls_s2 & ~m_q.pls_last;
  assign ext      = m_q.ctl[lsc_pkg::CTL_EXT];
  assign tmr      = m_q.ctl[lsc_pkg::CTL_WLO];
  assign cont     = m_q.ctl[lsc_pkg::CTL_CONT];
  assign lim_m1   = 16'(int_cycles(m_q.ctl[lsc_pkg::CTL_WHI:lsc_pkg::CTL_WLO])
                    - 17'h1);
  assign acc_max  = ext ? lsc_pkg::CNT_MAX : lim_m1;
  assign acc_nx   = (pulse && m_q.acc != acc_max) ?
                    16'(m_q.acc + 16'h1) : m_q.acc;
  assign done     = m_q.st == lsc_pkg::M_RUN &&
                    (ext ? sync_new : m_q.cyc == lim_m1);
  assign shadow_bad = l_q.ctl_shadow[lsc_pkg::CTL_EXT] &
                      l_q.ctl_shadow[lsc_pkg::CTL_WHI];

  always_comb begin
    m_d = m_q;
    m_d.ctl_s1 = l_q.ctl_tog;
    m_d.ctl_s2 = m_q.ctl_s1;
    m_d.ctl_seen = m_q.ctl_s2;
    m_d.syn_s1 = l_q.sync_tog;
    m_d.syn_s2 = m_q.syn_s1;
    m_d.syn_seen = m_q.syn_s2;
    m_d.pls_s1 = light_pulse;
    m_d.pls_s2 = m_q.pls_s1;
    m_d.pls_last = m_q.pls_s2;
    if (ctl_new) begin
      // shadow is stable: it only moves together with its toggle
      m_d.ctl = l_q.ctl_shadow;
      m_d.cyc = 16'h0000;
      m_d.acc = 16'h0000;
      if (!l_q.ctl_shadow[lsc_pkg::CTL_EN] || shadow_bad) begin
        m_d.st = lsc_pkg::M_OFF;
      end else if (l_q.ctl_shadow[lsc_pkg::CTL_EXT]) begin
        m_d.st = lsc_pkg::M_WAIT;
      end else begin
        m_d.st = lsc_pkg::M_RUN;
      end
    end else begin
      unique case (m_q.st)
        lsc_pkg::M_OFF: begin
          m_d.cyc = m_q.cyc;
        end
        lsc_pkg::M_WAIT: begin
          if (sync_new) begin
            m_d.st = lsc_pkg::M_RUN;
            m_d.cyc = 16'h0000;
            m_d.acc = 16'h0000;
          end
        end
        lsc_pkg::M_RUN: begin
          // timer saturates; longer periods are the master's problem
          m_d.cyc = (m_q.cyc == lsc_pkg::CNT_MAX) ?
                    m_q.cyc : 16'(m_q.cyc + 16'h1);
          m_d.acc = acc_nx;
          if (done) begin
            m_d.res = (ext && tmr) ? m_q.cyc : acc_nx;
            m_d.res_tog = ~m_q.res_tog;
            m_d.cyc = 16'h0000;
            m_d.acc = 16'h0000;
            if (!cont) begin
              m_d.st = lsc_pkg::M_OFF;
            end
          end
        end
        default: begin
          m_d.st = lsc_pkg::M_OFF;
        end
      endcase
    end
  end

  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      m_q <= M_RST;
    end else begin
      m_q <= m_d;
    end
  end

  assign fe.fe_on  = m_q.st != lsc_pkg::M_OFF;
  assign fe.ir_sel = m_q.ctl[lsc_pkg::CTL_IR];
  assign fe.full_scale_span =
    m_q.ctl[lsc_pkg::CTL_SHI:lsc_pkg::CTL_SLO];

  // ---- checks ----
  // helper counts: continuous results seen, cycles since a control change
  logic [1:0] cont_done_q;
  logic [4:0] ctl_quiet_q;

  always_ff @(posedge mclk) begin
    if (!rst_n || ctl_new) begin
      cont_done_q <= 2'h0;
      ctl_quiet_q <= 5'h00;
    end else begin
      if (done && cont && cont_done_q != 2'h3) begin
        cont_done_q <= 2'(cont_done_q + 2'h1);
      end
      if (ctl_quiet_q != 5'h1F) begin
        ctl_quiet_q <= 5'(ctl_quiet_q + 5'h1);
      end
    end
  end

  a_ctl_hold: assert property (@(posedge mclk) disable iff (!rst_n)
    !ctl_new |=> $stable(m_q.ctl))
    else $error("control byte changed without a write");

  a_reset_zero: assert property (@(posedge mclk) disable iff (!rst_n)
    $past(!rst_n) |-> (m_q.res == 16'h0000 && m_q.st == lsc_pkg::M_OFF))
    else $error("not powered down with zero result after reset");

  a_oneshot_off: assert property (@(posedge mclk) disable iff (!rst_n)
    (done && !cont && !ctl_new) |=> m_q.st == lsc_pkg::M_OFF ##1
    (m_q.st == lsc_pkg::M_OFF || $past(ctl_new)))
    else $error("one-shot did not power down");

  a_cont_restart: assert property (@(posedge mclk) disable iff (!rst_n)
    (done && cont && !ctl_new) |=>
    (m_q.st == lsc_pkg::M_RUN && m_q.cyc == 16'h0000 &&
     m_q.res == $past(ext && tmr ? m_q.cyc : acc_nx)))
    else $error("continuous conversion did not reload");

  a_refresh_cause: assert property (@(posedge mclk) disable iff (!rst_n)
    $changed(m_q.res_tog) |-> $past(done && !ctl_new))
    else $error("result refreshed without a completed conversion");

  a_en_off: assert property (@(posedge mclk) disable iff (!rst_n)
    (ctl_new && !l_q.ctl_shadow[lsc_pkg::CTL_EN]) |=>
    (m_q.st == lsc_pkg::M_OFF && !fe.fe_on))
    else $error("clear enable did not power down");

  a_reserved_idle: assert property (@(posedge mclk) disable iff (!rst_n)
    (ctl_new && shadow_bad) |=> (m_q.st == lsc_pkg::M_OFF &&
    m_q.ctl[lsc_pkg::CTL_EXT:lsc_pkg::CTL_WHI] == 2'b11))
    else $error("reserved timing code started a conversion");

  a_int_length: assert property (@(posedge mclk) disable iff (!rst_n)
    (m_q.st == lsc_pkg::M_RUN && !ext && m_q.ctl[3:2] == 2'h3 &&
     m_q.cyc == 16'h0000 && !ctl_new) |->
    ##15 (done || ctl_quiet_q < 5'h0F))
    else $error("short internal integration not 16 cycles");

  a_int_no_sync: assert property (@(posedge mclk) disable iff (!rst_n)
    (m_q.st == lsc_pkg::M_RUN && !ext && sync_new && !done && !ctl_new)
    |=> m_q.cyc == 16'($past(m_q.cyc) + 16'h1))
    else $error("restart command acted in internal timing");

  a_ext_timer: assert property (@(posedge mclk) disable iff (!rst_n)
    (done && ext && tmr && !ctl_new) |=> m_q.res == $past(m_q.cyc))
    else $error("timer result is not the cycle count");

  a_addr_ack: assert property (@(negedge scl) disable iff (!l_q.rst_s2)
    (l_q.st == lsc_pkg::L_ADDR && l_q.cnt == 4'h7 && !start && addr_hit)
    |=> (sda_oe ##1 ((sda_oe == (l_q.st == lsc_pkg::L_READ &&
    !l_q.sh[7])) || start)))
    else $error("matching address not acknowledged for one clock");

  a_addr_miss: assert property (@(negedge scl) disable iff (!l_q.rst_s2)
    (l_q.st == lsc_pkg::L_ADDR && l_q.cnt == 4'h7 && !start && !addr_hit)
    |=> (!sda_oe && l_q.st == lsc_pkg::L_IDLE))
    else $error("foreign address acknowledged");

  c_oneshot: cover property (@(posedge mclk) disable iff (!rst_n)
    done && !cont ##1 m_q.st == lsc_pkg::M_OFF);
  c_cont_two: cover property (@(posedge mclk) disable iff (!rst_n)
    cont_done_q == 2'h2);
  c_ext_timer: cover property (@(posedge mclk) disable iff (!rst_n)
    done && ext && tmr);
  c_bus_read: cover property (@(negedge scl) disable iff (!l_q.rst_s2)
    l_q.st == lsc_pkg::L_READ && l_q.cnt == 4'h8 && !sda_in);

endmodule

// >>> test/lsc_master.sv
// bus master model: start, bytes with acknowledge, stop
`timescale 1ns/1ps
module lsc_master (
  output logic      scl,
  output logic      sda_low,
  input  wire logic sda
);
  initial begin
    scl     = 1'b1;
    sda_low = 1'b0;
  end

  // data moves 4 ns after the fall so the slave never samples a moving line
  task automatic bit_io(input logic b, output logic got);
    #4 sda_low = ~b;
    #12 scl = 1'b1;
    #16 got = sda;
    scl = 1'b0;
  endtask

  task automatic pulses(input int n);
    repeat (n) begin
      #16 scl = 1'b0;
      #16 scl = 1'b1;
    end
  endtask

  // the high phase opens with data released, so the start is decodable
  task automatic start();
    scl = 1'b0;
    #4 sda_low = 1'b0;
    #12 scl = 1'b1;
    #8 sda_low = 1'b1;
    #8 scl = 1'b0;
  endtask

  task automatic stop();
    #4 sda_low = 1'b1;
    #12 scl = 1'b1;
    #8 sda_low = 1'b0;
  endtask

  // mack is the master's own acknowledge bit; 1 releases the line
  task automatic xfer(input logic [7:0] tx, input logic mack,
                      output logic [7:0] rx, output logic ack);
    for (int i = 7; i >= 0; i--) bit_io(tx[i], rx[i]);
    bit_io(mack, ack);
  endtask

  task automatic wr(input logic [6:0] a, input logic [7:0] p,
                    input logic [7:0] d, input logic with_d,
                    output logic nak);
    logic [7:0] r;
    logic       k;
    start();
    xfer({a, 1'b0}, 1'b1, r, nak);
    if (!nak) begin
      xfer(p, 1'b1, r, k);
      nak = k;
      if (with_d) begin
        xfer(d, 1'b1, r, k);
        nak = nak | k;
      end
    end
    stop();
  endtask

  // single byte read, ended by a not-acknowledge
  task automatic rd(input logic [6:0] a, output logic [7:0] d,
                    output logic nak);
    logic k;
    start();
    xfer({a, 1'b1}, 1'b1, d, nak);
    if (!nak) xfer(8'hFF, 1'b1, d, k);
    stop();
  endtask
endmodule

// >>> test/light_sensor_i2c_control_tb.sv
// self-checking bench of the light sensor control block
`timescale 1ns/1ps
module light_sensor_i2c_control_tb;
  localparam int unsigned N16 = 64;
  logic             mclk            = 1'b0;
  logic             rst_n           = 1'b0;
  logic             addr_select_pin = 1'b0;
  logic             light_pulse     = 1'b0;
  logic             pulse_en        = 1'b0;
  logic [1:0]       ph              = 2'h0;
  logic [15:0]      lfsr            = 16'h0032;
  logic [6:0]       dev             = 7'h44;
  logic             scl;
  logic             sda_low;
  logic             sda_out;
  logic             sda_oe;
  logic             sda;
  lsc_pkg::lsc_fe_t fe;
  logic [7:0]       r;
  logic [7:0]       lo;
  logic [7:0]       hi;
  logic [7:0]       c;
  logic             nak;
  int               n_mismatch      = 0;
  int               n_checks        = 0;
  int               dur;
  int               cyc;
  int               exp_v;
  time              t0;

  // open drain wire with pull-up
  assign sda = ~(sda_low | (sda_oe & ~sda_out));

  always #50 mclk = ~mclk;

  // pulses two cycles high, two low: slow enough for the synchroniser
  always @(posedge mclk) begin
    ph <= ph + 2'h1;
    light_pulse <= pulse_en & ph[1];
  end

  lsc_master i_mst (
    .scl     (scl),
    .sda_low (sda_low),
    .sda     (sda)
  );

  lsc_top #(.INT_CYC_16(N16)) i_dut (
    .mclk            (mclk),
    .rst_n           (rst_n),
    .scl             (scl),
    .sda_in          (sda),
    .sda_out         (sda_out),
    .sda_oe          (sda_oe),
    .addr_select_pin (addr_select_pin),
    .light_pulse     (light_pulse),
    .fe              (fe)
  );

  function automatic logic [15:0] nxt(input logic [15:0] v);
    return {v[14:0], v[15] ^ v[13] ^ v[12] ^ v[10]};
  endfunction

  function automatic int cyc_of(input logic [1:0] w);
    case (w)
      2'h0: return N16;
      2'h1: return 4096;
      2'h2: return 256;
      default: return 16;
    endcase
  endfunction

  function automatic logic rng(input logic [15:0] v, input int a,
                               input int b);
    return (v >= a) && (v <= b);
  endfunction

  task automatic end_sim();
    if (n_mismatch == 0 && n_checks > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask

  task automatic check(input string what, input logic [15:0] seen,
                       input logic [15:0] exp);
    n_checks++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("ERROR %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic tk(input int n);
    repeat (n) @(posedge mclk);
    #1;
  endtask

  // spacing keeps each control write apart on the oscillator side
  task automatic reg_wr(input logic [7:0] p, input logic [7:0] d);
    i_mst.wr(dev, p, d, 1'b1, nak);
    check("write ack", 16'(nak), 16'h0);
    tk(8);
  endtask

  task automatic reg_rd(input logic [7:0] p, output logic [7:0] d);
    i_mst.wr(dev, p, 8'h00, 1'b0, nak);
    i_mst.rd(dev, d, nak);
    check("read ack", 16'(nak), 16'h0);
  endtask

  task automatic one_shot(input logic [7:0] cb, input int n);
    i_mst.wr(dev, 8'h00, cb, 1'b1, nak);
    dur = 0;
    for (int t = 0; t < 20 && fe.fe_on !== 1'b1; t++) tk(1);
    while (fe.fe_on === 1'b1 && dur < n + 9) begin
      tk(1);
      dur++;
    end
    check("one-shot length", 16'(dur), 16'(n));
    reg_rd(8'h01, lo);
    reg_rd(8'h02, hi);
    check("pulse count", 16'(rng({hi, lo}, n / 4 - 1, n / 4 + 1)),
          16'h1);
  endtask

  initial begin
    #2_000_000;
    n_mismatch++;
    end_sim();
  end

  initial begin
    fork
      i_mst.pulses(14);
      begin
        repeat (3) @(posedge mclk);
        rst_n <= 1'b1;
      end
    join
    check("fe after reset", 16'(fe), 16'h0);
    for (int p = 0; p < 3; p++) begin
      reg_rd(8'(p), r);
      check("reset value", 16'(r), 16'h0);
    end
    i_mst.wr(7'h45, 8'h00, 8'h80, 1'b1, nak);
    check("foreign address", 16'(nak), 16'h1);
    pulse_en <= 1'b1;
    for (int w = 3; w >= 0; w--) begin
      lfsr = nxt(lfsr);
      c = {2'b10, lfsr[5], 1'b0, 2'(w), 2'(w) ^ {2{lfsr[0]}}};
      one_shot(c, cyc_of(2'(w)));
      check("spectrum", 16'(fe.ir_sel), 16'(c[5]));
      check("span", 16'(fe.full_scale_span), 16'(c[1:0]));
    end
    reg_wr(8'h00, 8'hCC);
    tk(100);
    check("continuous runs", 16'(fe.fe_on), 16'h1);
    i_mst.wr(dev, 8'h81, 8'h00, 1'b0, nak);
    tk(8);
    check("restart ignored", 16'(fe.fe_on), 16'h1);
    pulse_en <= 1'b0;
    tk(60);
    reg_rd(8'h01, lo);
    reg_rd(8'h02, hi);
    check("fresh result", {hi, lo}, 16'h0);
    reg_wr(8'h01, 8'h5A);
    reg_wr(8'h02, 8'hA5);
    reg_rd(8'h01, lo);
    reg_rd(8'h02, hi);
    check("result read-only", {hi, lo}, 16'h0);
    reg_wr(8'h00, 8'h4C);
    check("power down", 16'(fe.fe_on), 16'h0);
    reg_rd(8'h00, r);
    check("control kept", 16'(r), 16'h004C);
    for (int k = 6; k < 8; k++) begin
      lfsr = nxt(lfsr);
      c = {2'b11, lfsr[5], 3'(k), lfsr[1:0]};
      reg_wr(8'h00, c);
      check("reserved idle", 16'(fe.fe_on), 16'h0);
      reg_rd(8'h00, r);
      check("reserved stored", 16'(r), 16'(c));
    end
    pulse_en <= 1'b1;
    // the interval stays far below counter overflow
    for (int k = 5; k >= 4; k--) begin
      reg_wr(8'h00, {3'b110, 3'(k), 2'b00});
      i_mst.wr(dev, 8'h81, 8'h00, 1'b0, nak);
      t0 = $time;
      tk(300);
      i_mst.wr(dev, 8'h81, 8'h00, 1'b0, nak);
      cyc = int'(($time - t0) / 100);
      tk(8);
      reg_rd(8'h01, lo);
      reg_rd(8'h02, hi);
      exp_v = (k == 5) ? cyc : cyc / 4;
      check("external result", 16'(rng({hi, lo}, exp_v - 3, exp_v + 2)),
            16'h1);
    end
    reg_wr(8'h00, 8'h00);
    @(posedge mclk);
    addr_select_pin <= 1'b1;
    i_mst.pulses(4);
    dev = 7'h45;
    reg_rd(8'h00, r);
    check("second address", 16'(r), 16'h0);
    i_mst.rd(7'h44, r, nak);
    check("old address", 16'(nak), 16'h1);
    end_sim();
  end
endmodule
